// File: hdl/bps_sequencer.v
`timescale 1ns/1ps
`include "bps_defs.vh"
module bps_sequencer #(
  parameter [25:0] SETTLE_CYC = `BPS_T_SETTLE_MS * `BPS_CLK_KHZ,
  parameter [25:0] FIRST_CYC = `BPS_T_FIRST_MS * `BPS_CLK_KHZ,
  parameter [25:0] RAMP_CYC = `BPS_T_RAMP_MAX_MS * `BPS_CLK_KHZ,
  parameter [25:0] SECOND_CYC = `BPS_T_SECOND_MS * `BPS_CLK_KHZ,
  parameter [25:0] GOOD_CYC = `BPS_T_GOOD_MS * `BPS_CLK_KHZ
) (
  input wire CLOCK,
  input wire ARST_N,
  input wire POWER_ON_REQ,
  input wire ISO12_ABOVE_THRESHOLD,
  input wire FPGA_RAILS_GOOD,
  input wire ALL_SUPPLIES_GOOD,
  output reg ISO12_ENABLE,
  output reg FIRST_ENABLE,
  output reg RAMP_START,
  output reg SWITCH_CORE_RAIL_ENABLE,
  output reg STARTUP_RESET_N,
  output reg RAMP_TIMEOUT
);
  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  wire req_s;
  wire thr_s;
  wire fgood_s;
  wire agood_s;
  bps_sync u_req (.clk(CLOCK), .arst_n(ARST_N), .d(POWER_ON_REQ), .q(req_s));
  bps_sync u_thr (.clk(CLOCK), .arst_n(ARST_N), .d(ISO12_ABOVE_THRESHOLD), .q(thr_s));
  bps_sync u_fgd (.clk(CLOCK), .arst_n(ARST_N), .d(FPGA_RAILS_GOOD), .q(fgood_s));
  bps_sync u_agd (.clk(CLOCK), .arst_n(ARST_N), .d(ALL_SUPPLIES_GOOD), .q(agood_s));

  // ------------------------------------------------------------
  // Sequence state machine
  // ------------------------------------------------------------
  // State codes come from the shared header so every file agrees on them.
  localparam [2:0] ST_OFF = `BPS_ST_OFF;
  localparam [2:0] ST_SETTLE = `BPS_ST_SETTLE;
  localparam [2:0] ST_FIRST = `BPS_ST_FIRST;
  localparam [2:0] ST_RAMP = `BPS_ST_RAMP;
  localparam [2:0] ST_WAIT2 = `BPS_ST_WAIT2;
  localparam [2:0] ST_ON = `BPS_ST_ON;
  localparam [2:0] ST_DOWN = `BPS_ST_DOWN;

  reg [2:0] state;
  reg [`BPS_CNT_W-1:0] cnt;
  reg [`BPS_CNT_W-1:0] good_cnt;
  reg [2:0] next_state;
  reg [`BPS_CNT_W-1:0] next_cnt;
  reg next_iso;
  reg next_first;
  reg next_ramp;
  reg next_sw;
  wire [`BPS_CNT_W-1:0] cnt_inc;
  wire [`BPS_CNT_W-1:0] good_inc;
  wire withdraw;
  wire ramp_late;
  wire good_hold;

  assign cnt_inc = cnt + `BPS_CNT_ONE;
  assign good_inc = good_cnt + `BPS_CNT_ONE;
  // A withdrawn request overrides every step of the power-up walk.
  assign withdraw = !req_s && (state != ST_OFF) && (state != ST_DOWN);
  // The timer stops at the limit instead of wrapping into a false early pass.
  assign ramp_late = (state == ST_RAMP) && !fgood_s && (cnt_inc >= RAMP_CYC);
  assign good_hold = agood_s && req_s && (state == ST_ON);

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always @* begin
    next_state = state;
    next_cnt = cnt;
    next_iso = ISO12_ENABLE;
    next_first = FIRST_ENABLE;
    next_ramp = RAMP_START;
    next_sw = SWITCH_CORE_RAIL_ENABLE;
    if (withdraw) begin
      next_state = ST_DOWN;
      next_iso = 1'b0;
      next_ramp = 1'b0;
      next_sw = 1'b0;
      next_cnt = `BPS_CNT_ZERO;
    end else begin
      case (state)
        ST_OFF: begin
          next_cnt = `BPS_CNT_ZERO;
          if (req_s) begin
            next_iso = 1'b1;
            next_state = ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (cnt_inc >= SETTLE_CYC) begin
            next_first = 1'b1;
            next_cnt = `BPS_CNT_ZERO;
            next_state = ST_FIRST;
          end else begin
            next_cnt = cnt_inc;
          end
        end
        ST_FIRST: begin
          if (cnt_inc >= FIRST_CYC) begin
            next_ramp = 1'b1;
            next_cnt = `BPS_CNT_ZERO;
            next_state = ST_RAMP;
          end else begin
            next_cnt = cnt_inc;
          end
        end
        ST_RAMP: begin
          if (fgood_s) begin
            next_cnt = `BPS_CNT_ZERO;
            next_state = ST_WAIT2;
          end else if (!ramp_late) begin
            next_cnt = cnt_inc;
          end
        end
        ST_WAIT2: begin
          // gap before second enable
          // A rail that dips restarts the gap, so the core never sees a half-up bus.
          if (!fgood_s) begin
            next_cnt = `BPS_CNT_ZERO;
          end else if (cnt_inc >= SECOND_CYC) begin
            next_sw = 1'b1;
            next_state = ST_ON;
          end else begin
            next_cnt = cnt_inc;
          end
        end
        ST_ON: begin
          next_cnt = `BPS_CNT_ZERO;
        end
        ST_DOWN: begin
          // first enable drops below threshold
          // A new request is refused here until the 12V bus has drained.
          if (!thr_s) begin
            next_first = 1'b0;
            next_state = ST_OFF;
          end
        end
        default: begin
          next_state = ST_OFF;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // State registers
  // ------------------------------------------------------------
  // counter timebase, reset safe
  // Every enable clears on reset, so a board reset always cuts all rails.
  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= ST_OFF;
      cnt <= `BPS_CNT_ZERO;
      ISO12_ENABLE <= 1'b0;
      FIRST_ENABLE <= 1'b0;
      RAMP_START <= 1'b0;
      SWITCH_CORE_RAIL_ENABLE <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      ISO12_ENABLE <= next_iso;
      FIRST_ENABLE <= next_first;
      RAMP_START <= next_ramp;
      SWITCH_CORE_RAIL_ENABLE <= next_sw;
    end
  end

  // ------------------------------------------------------------
  // Ramp timeout flag
  // ------------------------------------------------------------
  // The flag only reports a slow ramp; the walk still waits for good rails,
  // since cutting power in mid-ramp would be worse than a late start.
  // slow ramp flag
  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      RAMP_TIMEOUT <= 1'b0;
    end else if (ramp_late) begin
      RAMP_TIMEOUT <= 1'b1;
    end else if (state == ST_OFF && req_s) begin
      RAMP_TIMEOUT <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Startup reset
  // ------------------------------------------------------------
  // Good time restarts on any glitch so a marginal rail never releases reset.
  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      good_cnt <= `BPS_CNT_ZERO;
      STARTUP_RESET_N <= 1'b0;
    end else if (!good_hold) begin
      good_cnt <= `BPS_CNT_ZERO;
      STARTUP_RESET_N <= 1'b0;
    end else if (good_cnt >= GOOD_CYC) begin
      STARTUP_RESET_N <= 1'b1;
    end else begin
      good_cnt <= good_inc;
    end
  end
endmodule // bps_sequencer

// File: hdl/bps_defs.vh
// Operation
// - After enabling the isolated 12V supply, wait 500 ms before first enable.
// - First enable stands at least 20 ms before the sequence ramp starts.
// - Allow the sequence ramp 5 to 9 ms to bring the rails up.
// - Wait at least 10 ms after ramp completion before the second enable.
// - Hold startup reset until all supplies are good for 100 ms.
// - Dropping the 12V enable starts the ramp falling at once.
// - Supplies ramp down while the isolated 12V stays above threshold.
// - First enable drops only once the isolated 12V falls below threshold.
// - Second enable drops together with the 12V supply enable.
`ifndef BPS_DEFS_VH
`define BPS_DEFS_VH
`define BPS_CLK_KHZ 50000
`define BPS_T_SETTLE_MS 500
`define BPS_T_FIRST_MS 20
`define BPS_T_RAMP_MAX_MS 9
`define BPS_T_SECOND_MS 10
`define BPS_T_GOOD_MS 100
`define BPS_CNT_W 26
`define BPS_CNT_ZERO 26'h000_0000
`define BPS_CNT_ONE 26'h000_0001
`define BPS_ST_OFF 3'h0
`define BPS_ST_SETTLE 3'h1
`define BPS_ST_FIRST 3'h2
`define BPS_ST_RAMP 3'h3
`define BPS_ST_WAIT2 3'h4
`define BPS_ST_ON 3'h5
`define BPS_ST_DOWN 3'h6
`endif

// File: hdl/bps_sync.v
`timescale 1ns/1ps
module bps_sync (
  input wire clk,
  input wire arst_n,
  input wire d,
  output reg q
);
  reg meta;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // bps_sync

// File: testbench/bps_sequencer_assertions.sv
`timescale 1ns/1ps
module bps_sequencer_assertions #(
  parameter SETTLE_CYC = 20,
  parameter FIRST_CYC = 10,
  parameter SECOND_CYC = 5,
  parameter GOOD_CYC = 12
) (
  input wire CLOCK,
  input wire ARST_N,
  input wire ISO12_ABOVE_THRESHOLD,
  input wire FPGA_RAILS_GOOD,
  input wire ALL_SUPPLIES_GOOD,
  input wire ISO12_ENABLE,
  input wire FIRST_ENABLE,
  input wire RAMP_START,
  input wire SWITCH_CORE_RAIL_ENABLE,
  input wire STARTUP_RESET_N
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);
  // The synchroniser and the state register add three edges, so the input must stay high four.
  sequence s_thr_up;
    ISO12_ABOVE_THRESHOLD [*4] ##0 FIRST_ENABLE;
  endsequence
  a_first_settle: assert property ($rose(FIRST_ENABLE) |-> $past(ISO12_ENABLE, SETTLE_CYC))
    else $error("first enable too early");
  a_ramp_wait: assert property ($rose(RAMP_START) |-> $past(FIRST_ENABLE, FIRST_CYC))
    else $error("ramp start too early");
  a_switch_wait: assert property ($rose(SWITCH_CORE_RAIL_ENABLE) |-> $past(FPGA_RAILS_GOOD, SECOND_CYC))
    else $error("second enable too early");
  a_reset_hold: assert property ($rose(STARTUP_RESET_N) |-> $past(ALL_SUPPLIES_GOOD, GOOD_CYC))
    else $error("startup reset released early");
  a_ramp_falls: assert property ($fell(ISO12_ENABLE) |-> !RAMP_START)
    else $error("ramp still up");
  a_first_stays: assert property (s_thr_up |=> FIRST_ENABLE)
    else $error("first enable dropped above threshold");
  a_switch_drop: assert property ($fell(ISO12_ENABLE) |-> !SWITCH_CORE_RAIL_ENABLE)
    else $error("second enable still up");
  a_reset_again: assert property (!ALL_SUPPLIES_GOOD [*5] |-> !STARTUP_RESET_N)
    else $error("startup reset not asserted");
endmodule // bps_sequencer_assertions

// File: testbench/bps_supply_model.sv
`timescale 1ns/1ps
// Supplies answer six cycles late, inside the ramp timeout of eight.
module bps_supply_model (
  input wire clk,
  input wire iso12_enable,
  input wire ramp_start,
  input wire switch_en,
  input wire stall,
  output wire iso12_above,
  output wire rails_good,
  output wire all_good
);
  reg [5:0] iso = 6'h00;
  reg [5:0] ramp = 6'h00;
  always @(negedge clk) begin
    iso <= {iso[4:0], iso12_enable};
    ramp <= {ramp[4:0], ramp_start};
  end
  assign iso12_above = iso[5];
  // A stall holds the rails below good, for slow ramps and dropouts.
  assign rails_good = ramp[5] & !stall;
  assign all_good = ramp[5] & switch_en & !stall;
endmodule // bps_supply_model

// File: testbench/bps_sequencer_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
`define WT(s) for (n = 0; n < 400 && (s) !== 1'b1; n++) @(negedge CLOCK); \
  if (n >= 400) begin errors++; stop_test(); end
module bps_sequencer_tb;
  reg CLOCK = 0;
  reg ARST_N = 0;
  reg req = 0;
  reg stall = 0;
  wire thr, rails, good, iso, first, ramp, sw, rst_n, tmo;
  int errors = 0;
  int tests_run = 0;
  int n;
  always #10 CLOCK = ~CLOCK;
  bps_sequencer #(.SETTLE_CYC(26'h0014), .FIRST_CYC(26'h000a), .RAMP_CYC(26'h0008),
    .SECOND_CYC(26'h0005), .GOOD_CYC(26'h000c)) bps_sequencer_i (.CLOCK(CLOCK),
    .ARST_N(ARST_N), .POWER_ON_REQ(req), .ISO12_ABOVE_THRESHOLD(thr), .FPGA_RAILS_GOOD(rails),
    .ALL_SUPPLIES_GOOD(good), .ISO12_ENABLE(iso), .FIRST_ENABLE(first), .RAMP_START(ramp),
    .SWITCH_CORE_RAIL_ENABLE(sw), .STARTUP_RESET_N(rst_n), .RAMP_TIMEOUT(tmo));
  bps_supply_model bps_supply_model_i (.clk(CLOCK), .iso12_enable(iso), .ramp_start(ramp),
    .switch_en(sw), .stall(stall), .iso12_above(thr), .rails_good(rails), .all_good(good));
  task stop_test;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task power_up;
    req = 1;
    `WT(iso)
    `WT(first)
    `CHK(n, 20)
    `WT(ramp)
    `CHK(n, 10)
    `WT(rails)
    `CHK(sw, 1'b0)
    `WT(sw)
    `CHK(n >= 5, 1)
    `CHK(tmo, 1'b0)
    `WT(rst_n)
    `CHK(n >= 12, 1)
  endtask
  task good_loss;
    stall = 1;
    `WT(!rst_n)
    `CHK(n, 3)
    `CHK({iso, first, ramp, sw}, 4'hf)
    stall = 0;
    `WT(rst_n)
    `CHK(n >= 12, 1)
  endtask
  task ramp_stall;
    stall = 1;
    req = 1;
    `WT(ramp)
    `CHK(tmo, 1'b0)
    repeat (12) @(negedge CLOCK);
    `CHK({tmo, sw}, 2'h2)
    stall = 0;
    `WT(sw)
    `CHK(tmo, 1'b1)
    `WT(rst_n)
    `CHK(n >= 12, 1)
  endtask
  task power_down;
    req = 0;
    `WT(!iso)
    `CHK({ramp, sw, rst_n}, 3'h0)
    `CHK({first, thr}, 2'h3)
    `WT(!first)
    `CHK(thr, 1'b0)
  endtask
  initial begin
    repeat (4) @(negedge CLOCK);
    `CHK({iso, first, ramp, sw, rst_n}, 5'h00)
    ARST_N = 1;
    power_up();
    good_loss();
    power_down();
    ramp_stall();
    power_down();
    power_up();
    ARST_N = 0;
    #1 `CHK({iso, first, ramp, sw, rst_n}, 5'h00)
    @(negedge CLOCK);
    ARST_N = 1;
    `WT(iso)
    `CHK(n, 3)
    stop_test();
  end
endmodule // bps_sequencer_tb
bind bps_sequencer bps_sequencer_assertions #(.SETTLE_CYC(SETTLE_CYC), .FIRST_CYC(FIRST_CYC),
  .SECOND_CYC(SECOND_CYC), .GOOD_CYC(GOOD_CYC)) bps_sequencer_assertions_i (.CLOCK(CLOCK),
  .ARST_N(ARST_N), .ISO12_ABOVE_THRESHOLD(ISO12_ABOVE_THRESHOLD), .FPGA_RAILS_GOOD(FPGA_RAILS_GOOD),
  .ALL_SUPPLIES_GOOD(ALL_SUPPLIES_GOOD), .ISO12_ENABLE(ISO12_ENABLE), .FIRST_ENABLE(FIRST_ENABLE),
  .RAMP_START(RAMP_START), .SWITCH_CORE_RAIL_ENABLE(SWITCH_CORE_RAIL_ENABLE),
  .STARTUP_RESET_N(STARTUP_RESET_N));
